// *** rvc_top.sv ***
// reset sequencing, vector generation and watchdog option loading
`timescale 1ns/1ps
module rvc_top import rvc_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // reset sources, asynchronous levels
  input wire logic [RVC_NSRC-1:0] rst_src,
  // flash controller
  input wire logic flash_cmd_busy,
  output logic flash_abort,
  output logic protect_active,
  output logic secure_active,
  // nonvolatile read port
  output logic nvm_rd,
  output logic [17:0] nvm_addr,
  input wire logic nvm_valid,
  input wire logic [7:0] nvm_rdata,
  input wire logic nvm_dfault,
  // cpu
  output logic cpu_hold,
  output logic [15:0] vec_addr,
  output logic vec_valid,
  input wire logic vec_fetch,
  input wire logic x_mask,
  input wire logic i_mask,
  input wire logic [RVC_NIRQ-1:0] irq_req,
  output logic irq_pending,
  output logic stop_wake,
  // watchdog configuration
  output logic [2:0] wdog_rate,
  output logic wdog_window
);
  rvc_opt_if ld_if ();

  // returns {valid, index}; lowest index carries the highest offset
  function automatic logic [4:0] irq_pick(input logic [RVC_NIRQ-1:0] q);
    logic [4:0] r;
    r = 5'h00;
    for (int i = RVC_NIRQ - 1; i >= 0; i--) begin
      if (q[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // bus state
  logic ap;
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [11:0] addr_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_rdata;
  logic wr_wdog;
  // software registers
  logic [2:0] wdog_rate_ff;
  logic wdog_win_ff;
  logic osc_en_ff;
  logic [7:0] vector_base_register_ff;
  logic dlink_ie_ff;
  logic tick_ie_ff;
  // reset synchroniser
  logic [RVC_NSRC-1:0] s1_ff;
  logic [RVC_NSRC-1:0] s2_ff;
  logic [RVC_NSRC-1:0] s3_ff;
  logic [RVC_NSRC-1:0] stb_ff;
  logic [RVC_NSRC-1:0] nxt_stb;
  logic [RVC_NSRC-1:0] rise;
  logic [RVC_NSRC-1:0] qual;
  logic any_rst;
  // sequencer
  rvc_state_t st_ff;
  logic start_ff;
  logic [15:0] rst_vec_ff;
  logic [7:0] flash_option_register_ff;
  logic protect_ff;
  logic secure_ff;
  logic abort_ff;
  logic load_done;
  logic hold_ff;
  // vectors and interrupts
  logic [15:0] vec_addr_ff;
  logic vec_valid_ff;
  logic irq_pend_ff;
  logic wake_ff;
  logic [RVC_NIRQ-1:0] irq_ok;
  logic [4:0] pick_now;
  logic [7:0] pick_ofs;

  // ---------------- bus slave ----------------
  assign ap = hsel && htrans[1] && hready;

  // reads take one wait state so that a write in the previous data
  // phase is already visible in the returned word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 12'h000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      wr_pend_ff <= ap && hwrite;
      rd_pend_ff <= ap && !hwrite;
      hreadyout_ff <= !(ap && !hwrite);
      if (ap) begin
        addr_ff <= (haddr[31:12] == 20'h00000) ? haddr[11:0] : 12'hfff;
      end
    end
  end

  always_comb begin
    nxt_rdata = 32'h00000000;
    unique case (addr_ff)
      RVC_OFS_WDOG: begin
        nxt_rdata[2:0] = wdog_rate_ff;
        nxt_rdata[RVC_WDOG_WIN_BIT] = wdog_win_ff;
      end
      RVC_OFS_OSC: nxt_rdata[RVC_OSC_EN_BIT] = osc_en_ff;
      RVC_OFS_VECTOR_BASE_REGISTER: nxt_rdata[7:0] = vector_base_register_ff;
      RVC_OFS_DLINK: nxt_rdata[RVC_DLINK_IE_BIT] = dlink_ie_ff;
      RVC_OFS_TICK: nxt_rdata[RVC_TICK_IE_BIT] = tick_ie_ff;
      RVC_OFS_STAT: begin
        nxt_rdata[7:0] = flash_option_register_ff;
        nxt_rdata[8] = protect_ff;
        nxt_rdata[9] = secure_ff;
        nxt_rdata[10] = (st_ff == RVC_ST_HOLD);
        nxt_rdata[11] = ld_if.busy;
        nxt_rdata[23:16] = rst_vec_ff[7:0];
      end
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (rd_pend_ff) begin
      hrdata_ff <= nxt_rdata;
    end
  end

  assign wr_wdog = wr_pend_ff && (addr_ff == RVC_OFS_WDOG);

  // plain control registers; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_en_ff <= 1'b0; // ram has no clear strobe, only registers
      vector_base_register_ff <= RVC_VECTOR_BASE_REGISTER_RST;
      dlink_ie_ff <= 1'b0;
      tick_ie_ff <= 1'b0;
    end else if (wr_pend_ff) begin
      unique case (addr_ff)
        RVC_OFS_OSC: osc_en_ff <= hwdata[RVC_OSC_EN_BIT];
        RVC_OFS_VECTOR_BASE_REGISTER: vector_base_register_ff <= hwdata[7:0];
        RVC_OFS_DLINK: dlink_ie_ff <= hwdata[RVC_DLINK_IE_BIT];
        RVC_OFS_TICK: tick_ie_ff <= hwdata[RVC_TICK_IE_BIT];
        default: ;
      endcase
    end
  end

  // the option load overrides a software write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdog_rate_ff <= RVC_WDOG_RATE_RST;
      wdog_win_ff <= 1'b0;
    end else if (load_done) begin
      wdog_rate_ff <= ~ld_if.opt[2:0];
      wdog_win_ff <= ~ld_if.opt[RVC_OPT_WIN_BIT];
    end else if (wr_wdog) begin
      wdog_rate_ff <= hwdata[2:0];
      wdog_win_ff <= hwdata[RVC_WDOG_WIN_BIT];
    end
  end

  // ---------------- reset sources ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      stb_ff <= '0;
    end else begin
      s1_ff <= rst_src;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      stb_ff <= nxt_stb;
    end
  end

  // a level counts only once the second and third stage agree
  assign nxt_stb = (s2_ff & s3_ff) | (stb_ff & (s2_ff | s3_ff));
  assign rise = nxt_stb & ~stb_ff;

  always_comb begin
    qual = rise;
    qual[RVC_SRC_CLKMON] = rise[RVC_SRC_CLKMON] && osc_en_ff;
    qual[RVC_SRC_WDOG] = rise[RVC_SRC_WDOG] && (|wdog_rate_ff);
  end

  assign any_rst = |qual;
  // a reset in the same cycle as done restarts the load instead
  assign load_done = ld_if.done && !any_rst && !start_ff;

  // ---------------- reset sequence ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= RVC_ST_HOLD;
      start_ff <= 1'b1;
      hold_ff <= 1'b1;
    end else begin
      start_ff <= any_rst;
      if (any_rst) begin
        st_ff <= RVC_ST_HOLD;
        hold_ff <= 1'b1;
      end else if (load_done) begin
        st_ff <= RVC_ST_RUN;
        hold_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_vec_ff <= RVC_VEC_POR;
    end else if (any_rst) begin
      if (|qual[3:0]) begin
        rst_vec_ff <= RVC_VEC_POR;
      end else if (qual[RVC_SRC_CLKMON]) begin
        rst_vec_ff <= RVC_VEC_CLKMON;
      end else begin
        rst_vec_ff <= RVC_VEC_WDOG;
      end
    end
  end

  // abort is a single pulse; the flash contents it leaves are undefined
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      abort_ff <= 1'b0;
    end else begin
      abort_ff <= any_rst && flash_cmd_busy;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_option_register_ff <= RVC_FLASH_OPTION_REGISTER_RST;
      protect_ff <= 1'b0;
      secure_ff <= 1'b0;
    end else if (load_done) begin
      flash_option_register_ff <= ld_if.opt;
      protect_ff <= ld_if.dfault;
      secure_ff <= ld_if.dfault;
    end
  end

  assign ld_if.start = start_ff;

  rvc_cfg_loader u_loader (
    .hclk(hclk),
    .hresetn(hresetn),
    .ld(ld_if.ldr),
    .nvm_rd(nvm_rd),
    .nvm_addr(nvm_addr),
    .nvm_valid(nvm_valid),
    .nvm_rdata(nvm_rdata),
    .nvm_dfault(nvm_dfault)
  );

  // ---------------- interrupts ----------------
  always_comb begin
    irq_ok = irq_req & {RVC_NIRQ{!i_mask}};
    irq_ok[0] = irq_req[0];
    irq_ok[1] = irq_req[1];
    irq_ok[RVC_IRQ_DERR] = irq_req[RVC_IRQ_DERR] && !x_mask;
    irq_ok[RVC_IRQ_DEXT] = irq_req[RVC_IRQ_DEXT] && !i_mask &&
      dlink_ie_ff;
    irq_ok[RVC_IRQ_TICK] = irq_req[RVC_IRQ_TICK] && !i_mask && tick_ie_ff;
  end

  assign pick_now = irq_pick(irq_ok);
  // a request gone by fetch time falls back to the spurious entry
  assign pick_ofs = pick_now[4] ? RVC_IRQ_OFS[pick_now[3:0]] :
    RVC_OFS_SPUR;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pend_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      irq_pend_ff <= (st_ff == RVC_ST_RUN) && !any_rst && pick_now[4];
      wake_ff <= irq_req[RVC_IRQ_DERR] ||
        (irq_req[RVC_IRQ_DEXT] && dlink_ie_ff);
    end
  end

  // one vector register serves reset and interrupt fetches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_addr_ff <= RVC_VEC_POR;
      vec_valid_ff <= 1'b0;
    end else begin
      vec_valid_ff <= 1'b0;
      if (st_ff == RVC_ST_HOLD && load_done) begin
        vec_addr_ff <= rst_vec_ff;
        vec_valid_ff <= 1'b1;
      end else if (st_ff == RVC_ST_RUN && !any_rst && vec_fetch) begin
        vec_addr_ff <= {vector_base_register_ff, 8'h00} + {8'h00, pick_ofs};
        vec_valid_ff <= 1'b1;
      end
    end
  end

  // ---------------- outputs ----------------
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign flash_abort = abort_ff;
  assign protect_active = protect_ff;
  assign secure_active = secure_ff;
  assign cpu_hold = hold_ff;
  assign vec_addr = vec_addr_ff;
  assign vec_valid = vec_valid_ff;
  assign irq_pending = irq_pend_ff;
  assign stop_wake = wake_ff;
  assign wdog_rate = wdog_rate_ff;
  assign wdog_window = wdog_win_ff;
endmodule

// *** rvc_pkg.sv ***
// constants, types and layout for the reset, vector and option loader
// Behaviour
// - POR, LOW_VOLTAGE_RESET, pin, illegal reset fetch $FFFE
// - clock monitor reset $FFFC, gated by osc enable
// - watchdog reset $FFFA, gated by nonzero rate
// - higher vector offset wins interrupt arbitration
// - vector equals base register plus source offset
// - vectors are 16-bit, offsets step two bytes
// - die error X-masked; external error I-masked, enabled
// - CPU held until option load finishes
// - double fault leaves protection and security active
// - reset aborts a running flash command
// - RAM untouched by reset; registers defined
// - watchdog rate and window loaded from option
// - option byte read from NV 0x3_FF0E
// - initial rate is inverse of option bits
// - initial window bit is inverse option bit3
package rvc_pkg;
  // register byte offsets
  localparam logic [11:0] RVC_OFS_WDOG = 12'h03c;
  localparam logic [11:0] RVC_OFS_OSC = 12'h040;
  localparam logic [11:0] RVC_OFS_VECTOR_BASE_REGISTER = 12'h044;
  localparam logic [11:0] RVC_OFS_DLINK = 12'h048;
  localparam logic [11:0] RVC_OFS_TICK = 12'h04c;
  localparam logic [11:0] RVC_OFS_STAT = 12'h050;
  // field positions
  localparam int RVC_WDOG_WIN_BIT = 7;
  localparam int RVC_OSC_EN_BIT = 7;
  localparam int RVC_DLINK_IE_BIT = 0;
  localparam int RVC_TICK_IE_BIT = 0;
  localparam int RVC_OPT_WIN_BIT = 3;
  // values after reset
  localparam logic [7:0] RVC_VECTOR_BASE_REGISTER_RST = 8'hff;
  localparam logic [2:0] RVC_WDOG_RATE_RST = 3'h0;
  localparam logic [7:0] RVC_FLASH_OPTION_REGISTER_RST = 8'hff;
  // reset vectors and the spurious interrupt offset
  localparam logic [15:0] RVC_VEC_POR = 16'hfffe;
  localparam logic [15:0] RVC_VEC_CLKMON = 16'hfffc;
  localparam logic [15:0] RVC_VEC_WDOG = 16'hfffa;
  localparam logic [7:0] RVC_OFS_SPUR = 8'h80;
  // nonvolatile configuration byte holding the option
  localparam logic [17:0] RVC_NV_CFG_ADDR = 18'h3ff0e;
  // reset source positions
  localparam int RVC_NSRC = 6;
  localparam int RVC_SRC_CLKMON = 4;
  localparam int RVC_SRC_WDOG = 5;
  // interrupt sources, index 0 has the highest offset
  localparam int RVC_NIRQ = 11;
  localparam int RVC_IRQ_DERR = 2;
  localparam int RVC_IRQ_DEXT = 3;
  localparam int RVC_IRQ_TICK = 4;
  // even offsets only, two bytes per handler address
  localparam logic [7:0] RVC_IRQ_OFS [RVC_NIRQ] = '{
    8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hf0, 8'hd8,
    8'hc8, 8'hc6, 8'hba, 8'hb8, 8'h8a};
  typedef enum logic [0:0] {RVC_ST_HOLD, RVC_ST_RUN} rvc_state_t;
  typedef enum logic [0:0] {RVC_LD_IDLE, RVC_LD_WAIT} rvc_ld_t;
endpackage

// *** rvc_opt_if.sv ***
// handshake between the sequencer and the option loader
`timescale 1ns/1ps
interface rvc_opt_if;
  logic start;
  logic done;
  logic busy;
  logic dfault;
  logic [7:0] opt;
  modport ctl (output start, input done, input busy, input dfault,
    input opt);
  modport ldr (input start, output done, output busy, output dfault,
    output opt);
endinterface

// *** rvc_cfg_loader.sv ***
// reads the option byte from nonvolatile memory on request
`timescale 1ns/1ps
module rvc_cfg_loader import rvc_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // sequencer side
  rvc_opt_if.ldr ld,
  // nonvolatile read port
  output logic nvm_rd,
  output logic [17:0] nvm_addr,
  input wire logic nvm_valid,
  input wire logic [7:0] nvm_rdata,
  input wire logic nvm_dfault
);
  rvc_ld_t st_ff;
  logic rd_ff;
  logic [17:0] addr_ff;
  logic done_ff;
  logic dfault_ff;
  logic [7:0] opt_ff;

  // a new start restarts the read, so a late answer is never used
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= RVC_LD_IDLE;
      rd_ff <= 1'b0;
      addr_ff <= 18'h00000;
    end else begin
      rd_ff <= ld.start;
      if (ld.start) begin
        st_ff <= RVC_LD_WAIT;
        addr_ff <= RVC_NV_CFG_ADDR;
      end else if (st_ff == RVC_LD_WAIT && nvm_valid && !rd_ff) begin
        st_ff <= RVC_LD_IDLE;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_ff <= 1'b0;
      dfault_ff <= 1'b0;
      opt_ff <= RVC_FLASH_OPTION_REGISTER_RST;
    end else begin
      done_ff <= 1'b0;
      if (!ld.start && st_ff == RVC_LD_WAIT && nvm_valid && !rd_ff) begin
        done_ff <= 1'b1;
        opt_ff <= nvm_rdata;
        dfault_ff <= nvm_dfault;
      end
    end
  end

  assign nvm_rd = rd_ff;
  assign nvm_addr = addr_ff;
  assign ld.done = done_ff;
  assign ld.busy = (st_ff == RVC_LD_WAIT);
  assign ld.dfault = dfault_ff;
  assign ld.opt = opt_ff;
endmodule

// *** rvc_top_assertions.sv ***
// concurrent checks on the reset, vector and option loader ports
`timescale 1ns/1ps
module rvc_chk import rvc_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // flash and option load
  input wire logic flash_cmd_busy,
  input wire logic flash_abort,
  input wire logic protect_active,
  input wire logic secure_active,
  input wire logic nvm_valid,
  input wire logic [17:0] nvm_addr,
  input wire logic [7:0] nvm_rdata,
  input wire logic nvm_dfault,
  // cpu side
  input wire logic cpu_hold,
  input wire logic [15:0] vec_addr,
  input wire logic vec_valid,
  input wire logic vec_fetch,
  input wire logic [RVC_NIRQ-1:0] irq_req,
  input wire logic [2:0] wdog_rate,
  input wire logic wdog_window
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_load_end;
    $fell(cpu_hold);
  endsequence
  sequence s_idle_fetch;
    vec_fetch && !cpu_hold && irq_req == '0 && $past(irq_req) == '0;
  endsequence
  // option data arrive two edges before the release is seen
  a_hold_until_load: assert property (s_load_end |->
    $past(nvm_valid, 2))
    else $error("cpu released without option data");
  a_rate_inverse: assert property (s_load_end |->
    wdog_rate == ~$past(nvm_rdata[2:0], 2))
    else $error("watchdog rate not inverse of option");
  a_window_inverse: assert property (s_load_end |->
    wdog_window == ~$past(nvm_rdata[3], 2))
    else $error("window bit not inverse of option");
  a_nv_address: assert property (nvm_valid |->
    nvm_addr == RVC_NV_CFG_ADDR)
    else $error("option read from wrong address");
  a_reset_vector: assert property (s_load_end |->
    vec_valid && (vec_addr == RVC_VEC_POR ||
    vec_addr == RVC_VEC_CLKMON || vec_addr == RVC_VEC_WDOG))
    else $error("no reset vector on release");
  a_fetch_answer: assert property (vec_fetch && !cpu_hold |=>
    vec_valid)
    else $error("vector fetch not answered");
  a_spurious_vector: assert property (s_idle_fetch |=>
    vec_addr[7:0] == RVC_OFS_SPUR)
    else $error("spurious vector missing");
  a_abort_pulse: assert property (flash_abort |->
    (cpu_hold && $past(flash_cmd_busy)) ##1 !flash_abort)
    else $error("flash abort without busy command");
  a_fault_protect: assert property (s_load_end |->
    protect_active == $past(nvm_dfault, 2) &&
    secure_active == protect_active)
    else $error("protection does not follow double fault");
endmodule

bind rvc_top rvc_chk u_chk (.hclk, .hresetn, .flash_cmd_busy, .flash_abort,
  .protect_active, .secure_active, .nvm_valid, .nvm_addr, .nvm_rdata,
  .nvm_dfault, .cpu_hold, .vec_addr, .vec_valid, .vec_fetch, .irq_req,
  .wdog_rate, .wdog_window);

// *** rvc_nvm_model.sv ***
// nonvolatile array answering option reads after a chosen delay
`timescale 1ns/1ps
module rvc_nvm_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // read port
  input wire logic nvm_rd,
  output logic nvm_valid,
  output logic [7:0] nvm_rdata,
  output logic nvm_dfault,
  // stored content and speed
  input wire logic [7:0] opt,
  input wire logic dfault,
  input wire logic [3:0] delay
);
  logic busy_ff;
  logic [3:0] cnt_ff;
  // data toggles outside the answer cycle so stale bytes never look valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      nvm_valid <= 1'b0;
      nvm_rdata <= 8'h00;
      nvm_dfault <= 1'b0;
    end else begin
      nvm_valid <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
      nvm_dfault <= ~nvm_dfault;
      if (nvm_rd) begin
        busy_ff <= 1'b1;
        cnt_ff <= delay;
      end else if (busy_ff && cnt_ff == 4'h0) begin
        busy_ff <= 1'b0;
        nvm_valid <= 1'b1;
        nvm_rdata <= opt;
        nvm_dfault <= dfault;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule

// *** testbench.sv ***
// self-checking bench for the reset, vector and option loader
`timescale 1ns/1ps
module testbench;
  import rvc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, hready;
  logic [RVC_NSRC-1:0] rst_src = '0;
  logic flash_cmd_busy = 1'b0;
  logic flash_abort, protect_active, secure_active;
  logic nvm_rd, nvm_valid, nvm_dfault;
  logic [17:0] nvm_addr;
  logic [7:0] nvm_rdata;
  logic cpu_hold, vec_valid, irq_pending, stop_wake, wdog_window;
  logic [15:0] vec_addr;
  logic vec_fetch = 1'b0;
  logic x_mask = 1'b0;
  logic i_mask = 1'b0;
  logic [RVC_NIRQ-1:0] irq_req = '0;
  logic [2:0] wdog_rate;
  logic [7:0] opt_v = 8'hf5;
  logic fault_v = 1'b0;
  logic [3:0] delay_v = 4'h0;
  logic [7:0] opts [4] = '{8'h00, 8'h07, 8'h08, 8'h3c};
  logic [10:0] reqs [10] = '{11'h7ff, 11'h006, 11'h00c, 11'h00c, 11'h004,
    11'h600, 11'h600, 11'h000, 11'h030, 11'h030};
  // x mask, i mask, die link and tick enable
  logic [2:0] ctl [10] = '{3'h6, 3'h0, 3'h4, 3'h5, 3'h3, 3'h3, 3'h0, 3'h0,
    3'h1, 3'h0};
  logic [7:0] expv [10] = '{8'hf8, 8'hf6, 8'h80, 8'hf2, 8'hf4, 8'h80,
    8'hb8, 8'h80, 8'hf0, 8'hd8};
  int fail_count = 0;
  int samples_checked = 0;
  int aborts = 0;
  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  always @(posedge hclk) if (flash_abort === 1'b1) aborts++;
  rvc_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rst_src,
    .flash_cmd_busy, .flash_abort, .protect_active, .secure_active, .nvm_rd,
    .nvm_addr, .nvm_valid, .nvm_rdata, .nvm_dfault, .cpu_hold, .vec_addr,
    .vec_valid, .vec_fetch, .x_mask, .i_mask, .irq_req, .irq_pending,
    .stop_wake, .wdog_rate, .wdog_window);
  rvc_nvm_model u_nvm (.hclk, .hresetn, .nvm_rd, .nvm_valid, .nvm_rdata,
    .nvm_dfault, .opt(opt_v), .dfault(fault_v), .delay(delay_v));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wait_ready();
    do @(posedge hclk); while (hready !== 1'b1);
  endtask
  // single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  // source held six cycles, longer than the glitch filter needs
  task automatic fire(input int s, input logic take);
    logic seen;
    seen = 1'b0;
    @(posedge hclk);
    rst_src[s] <= 1'b1;
    for (int n = 0; n < 12; n++) begin
      @(negedge hclk);
      if (cpu_hold === 1'b1) seen = 1'b1;
      @(posedge hclk);
      if (n == 5) rst_src[s] <= 1'b0;
    end
    check(seen, take);
  endtask
  task automatic landed(input logic [15:0] v);
    for (int n = 0; n < 60 && cpu_hold !== 1'b0; n++) @(negedge hclk);
    check({vec_valid, vec_addr}, {1'b1, v});
    check({wdog_window, wdog_rate}, {~opt_v[3:0]});
    @(posedge hclk);
  endtask
  initial begin
    #300000;
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    landed(RVC_VEC_POR);
    done("power-on load");
    delay_v <= 4'h5;
    for (int i = 0; i < 4; i++) begin
      opt_v <= opts[i];
      flash_cmd_busy <= (i == 2);
      fire(i, 1'b1);
      landed(RVC_VEC_POR);
    end
    check(aborts, 1);
    done("reset sources");
    fire(4, 1'b0);
    bus(1'b1, 32'h40, 32'h80);
    fire(4, 1'b1);
    landed(RVC_VEC_CLKMON);
    bus(1'b1, 32'h3c, 32'h00);
    bus(1'b0, 32'h3c, 32'h00);
    check(rd, 32'h00);
    fire(5, 1'b0);
    bus(1'b1, 32'h3c, 32'h83);
    bus(1'b0, 32'h3c, 32'h00);
    check(rd, 32'h83);
    check(hresp, 1'b0);
    fire(5, 1'b1);
    landed(RVC_VEC_WDOG);
    done("clock monitor and watchdog");
    fault_v <= 1'b1;
    fire(2, 1'b1);
    landed(RVC_VEC_POR);
    check({secure_active, protect_active}, 2'h3);
    bus(1'b0, 32'h50, 32'h00);
    check(rd[9:0], {2'h3, opt_v});
    fault_v <= 1'b0;
    fire(2, 1'b1);
    landed(RVC_VEC_POR);
    check({secure_active, protect_active}, 2'h0);
    bus(1'b1, 32'h1000, 32'hffffffff);
    bus(1'b0, 32'h1000, 32'h00);
    check(rd, 32'h00);
    done("double fault and map");
    bus(1'b1, 32'h44, 32'h12);
    for (int k = 0; k < 10; k++) begin
      bus(1'b1, 32'h48, {31'h0, ctl[k][0]});
      bus(1'b1, 32'h4c, {31'h0, ctl[k][0]});
      irq_req <= reqs[k];
      x_mask <= ctl[k][2];
      i_mask <= ctl[k][1];
      repeat (3) @(posedge hclk);
      vec_fetch <= 1'b1;
      @(posedge hclk);
      vec_fetch <= 1'b0;
      @(negedge hclk);
      check({vec_valid, vec_addr}, {9'h112, expv[k]});
      check(irq_pending, expv[k] != 8'h80);
      check(stop_wake, reqs[k][2] | (reqs[k][3] & ctl[k][0]));
    end
    done("interrupt vectors");
    wrap_up();
  end
endmodule
